// ===== src/povc_top.sv
// Purpose: On/off selection, store commands and output voltage settings.
// Assumes: A bus front end delivers decoded commands as strobes.
// Notes: Reads are combinational on rd_code, data comes from flip-flops, the format word from constants.
`timescale 1ns/1ps
`default_nettype none
module povc_top
	import povc_pkg::*;
#(
	parameter int WAIT_CYC = STORE_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write,
	input wire logic [15:0] cmd_wdata,
	input wire logic [7:0] rd_code,
	output logic [15:0] rd_data,
	output logic rd_ok,
	input wire logic remote_ctrl_pin,
	input wire logic [15:0] voltage_set_strap_pin,
	input wire logic [7:0] fault_set,
	output logic [7:0] fault_status,
	output logic out_enable,
	output logic out_immediate_off,
	output logic out_soft_off,
	output logic [15:0] vout_target,
	output logic [1:0] security_level,
	output logic store_busy
);
	povc_cfg_if cfg ();
	logic [7:0] onoff_q, op_q;
	logic [15:0] vnom_q, vtrim_q, vcal_q, vmax_q, vmax_lim;
	logic [31:0] lim_wide;
	logic [5:0] dirty_q;
	logic user_restored, wr, pin_on, bus_on, want_on;
	logic [15:0] vout_q;
	povc_out_t out_q;
	logic [1:0] sec_q;
	logic [7:0] fault_q;

	// Signed clip of a word to plus/minus the trim limit
	function automatic logic signed [17:0] clip_trim(input logic [15:0] v);
		logic signed [17:0] s;
		s = 18'(signed'(v));
		if (s > 18'(TRIM_LIMIT_LSB)) begin
			clip_trim = 18'(TRIM_LIMIT_LSB);
		end else if (s < -18'(TRIM_LIMIT_LSB)) begin
			clip_trim = -18'(TRIM_LIMIT_LSB);
		end else begin
			clip_trim = s;
		end
	endfunction

	// Ceiling allowed by the strap; combinational so the boot load clamps
	// too, and saturated since 115% of a high strap overflows 16 bits
	assign lim_wide = (32'(voltage_set_strap_pin) * VMAX_STRAP_PCT) / PCT_FULL;
	assign vmax_lim = (lim_wide > 32'h0000FFFF) ? 16'hFFFF
		: lim_wide[15:0]; // R20

	// Writes are refused while the store is settling
	assign wr = cmd_valid && cmd_write && !store_busy;
	assign cfg.onoff = onoff_q;
	assign cfg.op = op_q;
	assign cfg.vnom = vnom_q;
	assign cfg.vtrim = vtrim_q;
	assign cfg.vcal = vcal_q;
	assign cfg.vmax = vmax_q;
	assign cfg.dirty = dirty_q;

	povc_store #(.WAIT_CYC(WAIT_CYC)) u_store (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cmd_valid(cmd_valid && !cmd_write && !store_busy),
		.cmd_code(cmd_code),
		.cfg(cfg),
		.busy(store_busy),
		.user_restored(user_restored)
	);

	// Configuration registers; a restore reloads them all
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			onoff_q <= ONOFF_RESET;
			op_q <= OP_RESET;
			vnom_q <= VNOM_RESET;
			vtrim_q <= 16'h0000;
			vcal_q <= 16'h0000;
			vmax_q <= VMAX_RESET;
		end else if (cfg.load) begin
			onoff_q <= cfg.ld_onoff; // R08 R11
			op_q <= cfg.ld_op;
			vnom_q <= cfg.ld_vnom;
			vtrim_q <= cfg.ld_vtrim;
			vcal_q <= cfg.ld_vcal;
			vmax_q <= (cfg.ld_vmax > vmax_lim) ? vmax_lim : cfg.ld_vmax;
		end else if (wr) begin
			if (cmd_code == CMD_ON_OFF_CFG) begin
				onoff_q <= cmd_wdata[7:0];
			end else if (cmd_code == CMD_OPERATION) begin
				op_q <= cmd_wdata[7:0];
			end else if (cmd_code == CMD_VNOM) begin
				vnom_q <= cmd_wdata; // R16
			end else if (cmd_code == CMD_VTRIM) begin
				vtrim_q <= cmd_wdata;
			end else if (cmd_code == CMD_VCAL) begin
				vcal_q <= cmd_wdata;
			end else if (cmd_code == CMD_VMAX) begin
				vmax_q <= (cmd_wdata > vmax_lim) ? vmax_lim : cmd_wdata; // R20
			end
		end
	end

	// Track which words changed since the last restore
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dirty_q <= '0;
		end else if (cfg.load) begin
			dirty_q <= '0;
		end else if (wr) begin
			if (cmd_code == CMD_ON_OFF_CFG) begin
				dirty_q[0] <= 1'b1; // R09
			end else if (cmd_code == CMD_OPERATION) begin
				dirty_q[1] <= 1'b1;
			end else if (cmd_code == CMD_VNOM) begin
				dirty_q[2] <= 1'b1;
			end else if (cmd_code == CMD_VTRIM) begin
				dirty_q[3] <= 1'b1;
			end else if (cmd_code == CMD_VCAL) begin
				dirty_q[4] <= 1'b1;
			end else if (cmd_code == CMD_VMAX) begin
				dirty_q[5] <= 1'b1;
			end
		end
	end

	// Security level is set to one after each user restore
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sec_q <= SEC_LEVEL_RESET;
		end else if (user_restored) begin
			sec_q <= SEC_LEVEL_USER; // R12
		end
	end

	// Fault bits: a new fault wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fault_q <= '0;
		end else if (cmd_valid && !cmd_write && !store_busy
			&& cmd_code == CMD_CLEAR_FAULTS) begin
			fault_q <= fault_set; // R06
		end else begin
			fault_q <= fault_q | fault_set;
		end
	end

	// Enable sources; a disabled source places no condition
	assign pin_on = !onoff_q[ONOFF_PIN_BIT]
		|| (remote_ctrl_pin == onoff_q[ONOFF_POL_BIT]); // R03 R04
	assign bus_on = !onoff_q[ONOFF_BUS_BIT]
		|| (op_q[OP_EN_HI:OP_EN_LO] == OP_ENABLE); // R02 R21
	// With powerup-operation clear the output runs with no command needed
	assign want_on = !onoff_q[ONOFF_PWRUP_BIT] || (pin_on && bus_on); // R01 R22

	// Output state: which turn-off style applies depends on the source
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= POVC_OUT_OFF;
		end else begin
			case (out_q)
				POVC_OUT_OFF, POVC_OUT_SOFT_OFF, POVC_OUT_IMM_OFF: begin
					if (want_on) begin
						out_q <= POVC_OUT_ON;
					end else begin
						out_q <= POVC_OUT_OFF;
					end
				end
				POVC_OUT_ON: begin
					if (!want_on && !pin_on) begin
						out_q <= onoff_q[ONOFF_ACT_BIT] ? POVC_OUT_IMM_OFF
							: POVC_OUT_SOFT_OFF; // R05
					end else if (!want_on) begin
						out_q <= (op_q[OP_EN_HI:OP_EN_LO] == OP_SOFT_OFF)
							? POVC_OUT_SOFT_OFF : POVC_OUT_IMM_OFF; // R21
					end
				end
				default: out_q <= POVC_OUT_OFF;
			endcase
		end
	end

	// Target: nominal plus both offsets, clamped to the ceiling
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vout_q <= '0;
		end else begin
			vout_q <= 16'(clamp_v(vnom_q, vtrim_q, vcal_q, vmax_q));
		end
	end

	function automatic logic [15:0] clamp_v(input logic [15:0] n,
		input logic [15:0] t, input logic [15:0] c, input logic [15:0] m);
		logic signed [19:0] s;
		s = 20'(signed'({1'b0, n})) + 20'(clip_trim(t)) // R17
			+ 20'(clip_trim(c)); // R18
		if (s < 20'sh00000) begin
			clamp_v = 16'h0000;
		end else if (s > 20'(signed'({1'b0, m}))) begin
			clamp_v = m; // R19
		end else begin
			clamp_v = s[15:0];
		end
	endfunction

	// Register read; the format register has no write path
	always_comb begin
		rd_ok = 1'b1;
		if (rd_code == CMD_ON_OFF_CFG) begin
			rd_data = {8'h00, onoff_q};
		end else if (rd_code == CMD_OPERATION) begin
			rd_data = {8'h00, op_q};
		end else if (rd_code == CMD_VFMT) begin
			rd_data = {8'h00, VFMT_LINEAR, VFMT_EXP}; // R14 R15
		end else if (rd_code == CMD_VNOM) begin
			rd_data = vnom_q;
		end else if (rd_code == CMD_VTRIM) begin
			rd_data = vtrim_q;
		end else if (rd_code == CMD_VCAL) begin
			rd_data = vcal_q;
		end else if (rd_code == CMD_VMAX) begin
			rd_data = vmax_q;
		end else begin
			rd_data = 16'h0000;
			rd_ok = 1'b0;
		end
	end

	assign fault_status = fault_q;
	assign out_enable = (out_q == POVC_OUT_ON);
	assign out_soft_off = (out_q == POVC_OUT_SOFT_OFF);
	assign out_immediate_off = (out_q == POVC_OUT_IMM_OFF);
	assign vout_target = vout_q;
	assign security_level = sec_q;
endmodule
`default_nettype wire

// ===== src/povc_pkg.sv
// Purpose: Shared constants and types for the on/off and output voltage
//   command block of a point-of-load regulator management interface.
// Assumes: Commands arrive already decoded as code, data and strobes.
// Notes: Voltage words are in the linear format with a fixed exponent.
// Behaviour
// (R01) Powerup-operation set keeps output off until enabled
// (R02) Bus enable mode: ignore or require OPERATION on
// (R03) Pin mode: ignore pin or require it asserted
// (R04) Pin polarity picks the asserted pin level
// (R05) Disable action picks soft or immediate pin off
// (R06) Fault-clear command resets all fault status bits
// (R07) Store-default command saves configuration to default store
// (R08) Restore-default command reloads configuration from default store
// (R09) Store-user saves settings changed since last restore
// (R10) Host waits 20 ms after store-user
// (R11) Restore-user runs at power-up, overrides defaults
// (R12) Restore-user sets security level to one
// (R13) Host waits 20 ms after restore-user
// (R14) Format register read-only, low five bits exponent
// (R15) Format bits 7:5 encode linear, VID, direct
// (R16) Nominal voltage is a 16-bit unsigned read/write word
// (R17) Trim is signed, limited to plus/minus 150 mV
// (R18) Calibration offset acts exactly like trim
// (R19) Commanded voltage above ceiling is clamped to it
// (R20) Ceiling never accepted above 115% of strap voltage
// (R21) OPERATION bits 7:6: off, soft off, enable
// (R22) Pin and bus modes both set need both on
package povc_pkg;
	// Command codes
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STORE_DEF = 8'h11;
	localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
	localparam logic [7:0] CMD_STORE_USER = 8'h15;
	localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
	localparam logic [7:0] CMD_VFMT = 8'h20;
	localparam logic [7:0] CMD_VNOM = 8'h21;
	localparam logic [7:0] CMD_VTRIM = 8'h22;
	localparam logic [7:0] CMD_VCAL = 8'h23;
	localparam logic [7:0] CMD_VMAX = 8'h24;
	// On/off configuration bit positions
	localparam int ONOFF_PWRUP_BIT = 4;
	localparam int ONOFF_BUS_BIT = 3;
	localparam int ONOFF_PIN_BIT = 2;
	localparam int ONOFF_POL_BIT = 1;
	localparam int ONOFF_ACT_BIT = 0;
	// OPERATION on/off field
	localparam int OP_EN_HI = 7;
	localparam int OP_EN_LO = 6;
	localparam logic [1:0] OP_IMM_OFF = 2'h0;
	localparam logic [1:0] OP_SOFT_OFF = 2'h1;
	localparam logic [1:0] OP_ENABLE = 2'h2;
	// Voltage format register layout
	localparam int VFMT_MODE_LO = 5;
	localparam logic [2:0] VFMT_LINEAR = 3'h0;
	localparam logic [2:0] VFMT_VID = 3'h1;
	localparam logic [2:0] VFMT_DIRECT = 3'h2;
	// Fixed exponent -12 (1/4096 V per lsb)
	localparam logic [4:0] VFMT_EXP = 5'h14;
	localparam int VOLT_LSB_PER_V = 4096;
	// Trim limit in millivolts, and in lsb
	localparam int TRIM_LIMIT_MV = 150;
	localparam int TRIM_LIMIT_LSB = (TRIM_LIMIT_MV * VOLT_LSB_PER_V) / 1000;
	// Ceiling may reach this percentage of the strap voltage
	localparam int VMAX_STRAP_PCT = 115;
	localparam int PCT_FULL = 100;
	// Reset values
	localparam logic [7:0] ONOFF_RESET = 8'h17;
	localparam logic [7:0] OP_RESET = 8'h00;
	localparam logic [15:0] VNOM_RESET = 16'h0000;
	localparam logic [15:0] VMAX_RESET = 16'hFFFF;
	localparam logic [1:0] SEC_LEVEL_USER = 2'h1;
	localparam logic [1:0] SEC_LEVEL_RESET = 2'h0;
	// Settle wait after store/restore of the user store
	localparam int STORE_WAIT_MS = 20;
	localparam int CLK_KHZ = 20000;
	localparam int STORE_WAIT_CYC = STORE_WAIT_MS * CLK_KHZ;
	// Output drive states
	typedef enum logic [1:0] {
		POVC_OUT_OFF,
		POVC_OUT_ON,
		POVC_OUT_SOFT_OFF,
		POVC_OUT_IMM_OFF
	} povc_out_t;
	// Store sequencer
	typedef enum logic [1:0] {
		POVC_NV_IDLE,
		POVC_NV_BUSY
	} povc_nv_t;
endpackage

// ===== src/povc_cfg_if.sv
// Purpose: Carries the live configuration words between block modules.
// Assumes: Single clock domain.
// Notes: The top module drives, the store module reads and reloads.
`timescale 1ns/1ps
`default_nettype none
interface povc_cfg_if;
	logic [7:0] onoff;
	logic [7:0] op;
	logic [15:0] vnom;
	logic [15:0] vtrim;
	logic [15:0] vcal;
	logic [15:0] vmax;
	logic [5:0] dirty;
	logic load;
	logic [7:0] ld_onoff;
	logic [7:0] ld_op;
	logic [15:0] ld_vnom;
	logic [15:0] ld_vtrim;
	logic [15:0] ld_vcal;
	logic [15:0] ld_vmax;
	modport top (
		output onoff, op, vnom, vtrim, vcal, vmax, dirty,
		input load, ld_onoff, ld_op, ld_vnom, ld_vtrim, ld_vcal, ld_vmax
	);
	modport store (
		input onoff, op, vnom, vtrim, vcal, vmax, dirty,
		output load, ld_onoff, ld_op, ld_vnom, ld_vtrim, ld_vcal, ld_vmax
	);
endinterface
`default_nettype wire

// ===== src/povc_store.sv
// Purpose: Default and user configuration stores with settle timing.
// Assumes: Stores are modelled as flip-flop arrays.
// Notes: Busy lasts the settle time; the host must not command meanwhile.
`timescale 1ns/1ps
`default_nettype none
module povc_store
	import povc_pkg::*;
#(
	parameter int WAIT_CYC = STORE_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	povc_cfg_if.store cfg,
	output logic busy,
	output logic user_restored
);
	localparam int NW = 6;
	logic [15:0] dflt_q [NW];
	logic [15:0] user_q [NW];
	logic [NW-1:0] user_has_q;
	logic [31:0] cnt_q;
	logic boot_q;
	povc_nv_t st_q;
	logic [15:0] cur [NW];
	logic [15:0] img [NW];
	logic do_sd, do_rd, do_su, do_ru;

	assign cur[0] = {8'h00, cfg.onoff};
	assign cur[1] = {8'h00, cfg.op};
	assign cur[2] = cfg.vnom;
	assign cur[3] = cfg.vtrim;
	assign cur[4] = cfg.vcal;
	assign cur[5] = cfg.vmax;
	assign do_sd = cmd_valid && cmd_code == CMD_STORE_DEF;
	assign do_rd = cmd_valid && cmd_code == CMD_RESTORE_DEF;
	assign do_su = cmd_valid && cmd_code == CMD_STORE_USER;
	// Power-up runs the user restore once, after reset release
	assign do_ru = boot_q || (cmd_valid && cmd_code == CMD_RESTORE_USER); // R11

	// Default store image
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dflt_q <= '{ {8'h00, ONOFF_RESET}, {8'h00, OP_RESET}, VNOM_RESET,
				16'h0000, 16'h0000, VMAX_RESET };
		end else if (do_sd) begin
			dflt_q <= cur; // R07
		end
	end

	// User store saves only words changed since the last restore
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			user_q <= '{default: 16'h0000};
			user_has_q <= '0;
		end else if (do_su) begin
			for (int i = 0; i < NW; i++) begin
				if (cfg.dirty[i]) begin
					user_q[i] <= cur[i]; // R09
					user_has_q[i] <= 1'b1;
				end
			end
		end
	end

	// Image to load: default words, or on a user restore the current words overridden by saved user words
	always_comb begin
		for (int i = 0; i < NW; i++) begin
			if (do_ru && user_has_q[i]) begin
				img[i] = user_q[i]; // R11
			end else if (do_ru) begin
				img[i] = cur[i];
			end else begin
				img[i] = dflt_q[i]; // R08
			end
		end
	end
	assign cfg.load = do_rd || do_ru;
	assign cfg.ld_onoff = img[0][7:0];
	assign cfg.ld_op = img[1][7:0];
	assign cfg.ld_vnom = img[2];
	assign cfg.ld_vtrim = img[3];
	assign cfg.ld_vcal = img[4];
	assign cfg.ld_vmax = img[5];
	assign user_restored = do_ru;

	// Boot flag and settle timer; a write to flash is not instant
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			boot_q <= 1'b1;
			st_q <= POVC_NV_IDLE;
			cnt_q <= '0;
		end else begin
			boot_q <= 1'b0;
			case (st_q)
				POVC_NV_IDLE: begin
					if (do_su || do_ru) begin
						st_q <= POVC_NV_BUSY;
						cnt_q <= 32'(WAIT_CYC - 1);
					end
				end
				POVC_NV_BUSY: begin
					if (cnt_q == '0) begin
						st_q <= POVC_NV_IDLE;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				default: st_q <= POVC_NV_IDLE;
			endcase
		end
	end
	assign busy = (st_q == POVC_NV_BUSY); // R10 R13
endmodule
`default_nettype wire

// ===== dv/povc_host.sv
// Purpose: Host model that issues decoded commands to the block.
// Assumes: One command per strobe, launched on a rising edge.
// Notes: Idle lines carry the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module povc_host (
	input wire logic clk_sys,
	input wire logic store_busy,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_write,
	output logic [15:0] cmd_wdata,
	output logic tmo
);
	// Quiet lines at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_write = 1'b0;
		cmd_wdata = 16'h0000;
		tmo = 1'b0;
	end
	// A polite host sits out the settle time, a rude one gets dropped
	task automatic send(input logic [7:0] c, input logic w,
		input logic [15:0] d, input bit polite);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (polite && store_busy !== 1'b0 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 50)
			tmo = 1'b1;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_write <= w;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		cmd_write <= ~w;
		cmd_wdata <= ~d;
		// Busy only shows one edge after the strobe is taken
		repeat (2) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== dv/povc_top_assertions.sv
// Purpose: Port-level checks of the on/off and voltage command block.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Settle length is counted in helper logic, not unrolled.
`timescale 1ns/1ps
`default_nettype none
module povc_top_assertions
	import povc_pkg::*;
#(
	parameter int WAIT_CYC = STORE_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write,
	input wire logic [7:0] rd_code,
	input wire logic [15:0] rd_data,
	input wire logic rd_ok,
	input wire logic [15:0] voltage_set_strap_pin,
	input wire logic [7:0] fault_set,
	input wire logic [7:0] fault_status,
	input wire logic out_enable,
	input wire logic out_immediate_off,
	input wire logic out_soft_off,
	input wire logic [15:0] vout_target,
	input wire logic [1:0] security_level,
	input wire logic store_busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [31:0] busy_cnt_q;
	logic go;
	// Busy cycles so far; a repetition this long would crawl
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			busy_cnt_q <= 32'h0;
		else
			busy_cnt_q <= store_busy ? busy_cnt_q + 32'h1 : 32'h0;
	end
	assign go = cmd_valid && !store_busy && !cmd_write;
	property p_store_go;
		go && (cmd_code == CMD_STORE_USER || cmd_code == CMD_RESTORE_USER)
			|=> store_busy;
	endproperty
	a_store_go: assert property (p_store_go) else $error("no busy");
	property p_busy_len;
		store_busy |-> busy_cnt_q < WAIT_CYC;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy long");
	property p_busy_end;
		$fell(store_busy) |-> busy_cnt_q == WAIT_CYC;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy short");
	property p_sec;
		store_busy |-> security_level == SEC_LEVEL_USER;
	endproperty
	a_sec: assert property (p_sec) else $error("security level");
	property p_clear;
		go && cmd_code == CMD_CLEAR_FAULTS && fault_set == 8'h00
			|=> fault_status == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("faults kept");
	property p_sticky;
		fault_set != 8'h00 |=> (fault_status & $past(fault_set))
			== $past(fault_set);
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault lost");
	property p_ceil;
		32'(vout_target) * PCT_FULL
			<= 32'(voltage_set_strap_pin) * VMAX_STRAP_PCT;
	endproperty
	a_ceil: assert property (p_ceil) else $error("over ceiling");
	property p_fmt;
		rd_code == CMD_VFMT |-> rd_ok && rd_data[7:0]
			== {VFMT_LINEAR, VFMT_EXP};
	endproperty
	a_fmt: assert property (p_fmt) else $error("format word");
	property p_state;
		$onehot0({out_enable, out_soft_off, out_immediate_off});
	endproperty
	a_state: assert property (p_state) else $error("out state");
	// Main scenarios reached
	c_store: cover property (go && cmd_code == CMD_STORE_USER);
	c_done: cover property ($fell(store_busy));
	c_on: cover property ($rose(out_enable));
endmodule
bind povc_top povc_top_assertions #(.WAIT_CYC(WAIT_CYC)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_write(cmd_write), .rd_code(rd_code),
	.rd_data(rd_data), .rd_ok(rd_ok),
	.voltage_set_strap_pin(voltage_set_strap_pin), .fault_set(fault_set),
	.fault_status(fault_status), .out_enable(out_enable),
	.out_immediate_off(out_immediate_off), .out_soft_off(out_soft_off),
	.vout_target(vout_target), .security_level(security_level),
	.store_busy(store_busy));
`default_nettype wire

// ===== dv/pmbus_onoff_vout_config_tb.sv
// Purpose: Self-checking bench for the on/off and voltage command block.
// Assumes: Settle wait shortened to 8 cycles; strap 1 V, raised once.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none
module pmbus_onoff_vout_config_tb;
	import povc_pkg::*;
	localparam logic [15:0] STRAP = 16'h1000;
	localparam logic [15:0] STRAP_HI = 16'h1400;
	localparam logic [15:0] LIM_HI =
		16'((32'(STRAP_HI) * VMAX_STRAP_PCT) / PCT_FULL);
	logic [15:0] strap = STRAP;
	localparam logic [15:0] LIM = 16'((32'h1000 * VMAX_STRAP_PCT) / PCT_FULL);
	localparam logic [15:0] TRIM = 16'(TRIM_LIMIT_LSB);
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid, cmd_write, rd_ok, remote_ctrl_pin, out_enable, tmo;
	logic out_immediate_off, out_soft_off, store_busy;
	logic [7:0] cmd_code, rd_code, fault_set, fault_status;
	logic [15:0] cmd_wdata, rd_data, vout_target;
	logic [1:0] security_level;
	int n_mismatch = 0;
	int n_checks = 0;
	logic seen_clr = 1'b0;
	logic [2:0] seen_q = 3'h0;
	// {config, operation, pin, expected enable/soft/immediate}
	logic [19:0] tbl [9] = '{20'h1C80A, 20'h1C804, 20'h1C001, 20'h1880C,
		20'h1840A, 20'h14004, 20'h17001, 20'h1700C, 20'h0400C};
	always #25 clk_sys = ~clk_sys;
	povc_host host (.clk_sys(clk_sys), .store_busy(store_busy),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_wdata(cmd_wdata), .tmo(tmo));
	povc_top #(.WAIT_CYC(8)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_wdata(cmd_wdata), .rd_code(rd_code), .rd_data(rd_data),
		.rd_ok(rd_ok), .remote_ctrl_pin(remote_ctrl_pin),
		.voltage_set_strap_pin(strap), .fault_set(fault_set),
		.fault_status(fault_status), .out_enable(out_enable),
		.out_immediate_off(out_immediate_off), .out_soft_off(out_soft_off),
		.vout_target(vout_target), .security_level(security_level),
		.store_busy(store_busy));
	// Off styles stand one cycle, so keep the last active state seen
	always @(negedge clk_sys) begin
		if (seen_clr)
			seen_q <= 3'h0;
		else if ({out_enable, out_soft_off, out_immediate_off} != 3'h0)
			seen_q <= {out_enable, out_soft_off, out_immediate_off};
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host.send(c, 1'b1, d, 1'b1);
	endtask
	task automatic cmd(input logic [7:0] c);
		host.send(c, 1'b0, 16'h0000, 1'b1);
	endtask
	// Reads are combinational, so look half a cycle later
	task automatic rd(input logic [7:0] c, input logic [15:0] e,
		input logic ok);
		@(posedge clk_sys);
		rd_code <= c;
		@(negedge clk_sys);
		chk("rd_data", e, rd_data);
		chk("rd_ok", {15'h0, ok}, {15'h0, rd_ok});
	endtask
	task automatic tgt(input logic [15:0] e);
		@(negedge clk_sys);
		chk("vout_target", e, vout_target);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		remote_ctrl_pin = 1'b0;
		fault_set = 8'h00;
		rd_code = 8'h00;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		wr(CMD_VFMT, 16'h00FF);
		rd(CMD_VFMT, {8'h00, VFMT_LINEAR, VFMT_EXP}, 1'b1);
		rd(8'hFF, 16'h0000, 1'b0);
		rd(CMD_VMAX, LIM, 1'b1);
		chk("security_level", 16'h1, {14'h0, security_level});
		chk("out_enable", 16'h0, {15'h0, out_enable});
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_sys);
			seen_clr <= 1'b1;
			@(posedge clk_sys);
			seen_clr <= 1'b0;
			wr(CMD_ON_OFF_CFG, {8'h00, tbl[i][19:12]});
			wr(CMD_OPERATION, {8'h00, tbl[i][11:4]});
			@(posedge clk_sys);
			remote_ctrl_pin <= tbl[i][3];
			repeat (4) @(negedge clk_sys);
			chk("out_state", {13'h0, tbl[i][2:0]},
				{13'h0, seen_q});
		end
		wr(CMD_VNOM, 16'h0800);
		rd(CMD_VNOM, 16'h0800, 1'b1);
		wr(CMD_VTRIM, 16'h7FFF);
		tgt(16'h0800 + TRIM);
		wr(CMD_VCAL, 16'h8000);
		tgt(16'h0800);
		wr(CMD_VTRIM, 16'hFF9C);
		wr(CMD_VCAL, 16'h0000);
		rd(CMD_VTRIM, 16'hFF9C, 1'b1);
		tgt(16'h079C);
		wr(CMD_VNOM, 16'h2000);
		tgt(LIM);
		wr(CMD_VMAX, 16'hFFFF);
		rd(CMD_VMAX, LIM, 1'b1);
		wr(CMD_VMAX, 16'h1100);
		rd(CMD_VMAX, 16'h1100, 1'b1);
		tgt(16'h1100);
		// A higher strap lets the ceiling rise with it
		@(posedge clk_sys);
		strap <= STRAP_HI;
		wr(CMD_VMAX, 16'hFFFF);
		rd(CMD_VMAX, LIM_HI, 1'b1);
		tgt(LIM_HI);
		wr(CMD_VMAX, 16'h1100);
		// Sticky fault, then clear
		@(posedge clk_sys);
		fault_set <= 8'h05;
		@(posedge clk_sys);
		fault_set <= 8'h00;
		@(negedge clk_sys);
		chk("fault_status", 16'h0005, {8'h00, fault_status});
		cmd(CMD_CLEAR_FAULTS);
		chk("fault_status", 16'h0000, {8'h00, fault_status});
		// A fault standing during the clear survives it
		@(posedge clk_sys);
		fault_set <= 8'h02;
		cmd(CMD_CLEAR_FAULTS);
		chk("fault_status", 16'h0002, {8'h00, fault_status});
		@(posedge clk_sys);
		fault_set <= 8'h00;
		// Stores; a write during the settle time must be dropped
		wr(CMD_VNOM, 16'h0123);
		cmd(CMD_STORE_USER);
		chk("store_busy", 16'h1, {15'h0, store_busy});
		host.send(CMD_VNOM, 1'b1, 16'h0456, 1'b0);
		rd(CMD_VNOM, 16'h0123, 1'b1);
		wr(CMD_VNOM, 16'h0321);
		cmd(CMD_STORE_DEF);
		wr(CMD_VNOM, 16'h0555);
		cmd(CMD_RESTORE_DEF);
		wr(CMD_VCAL, 16'h0000);
		rd(CMD_VNOM, 16'h0321, 1'b1);
		cmd(CMD_RESTORE_USER);
		wr(CMD_VCAL, 16'h0000);
		rd(CMD_VNOM, 16'h0123, 1'b1);
		chk("security_level", 16'h1, {14'h0, security_level});
		chk("host_wait", 16'h0, {15'h0, tmo});
		complete_run();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
